/* File: inc/chan_defines.vh */
// shared constants for the channel bit-bang and wake control block
`ifndef CHAN_DEFINES_VH
`define CHAN_DEFINES_VH
// ----------------------------------------
// io mode command values
// ----------------------------------------
`define IOMODE_NORMAL 8'h00
`define IOMODE_ASYNC_BB 8'h01
`define IOMODE_SYNC_BB 8'h04
// ----------------------------------------
// channel base modes
// ----------------------------------------
`define CHMODE_UART 1'b0
`define CHMODE_FIFO 1'b1
// ----------------------------------------
// prescaler limits and fraction step
// ----------------------------------------
`define DIV_INT_MIN 15'h0002
`define DIV_INT_MAX 15'h4000
`define FRAC_EIGHTHS 4'h8
// ----------------------------------------
// timing: clock rate and flush tick
// ----------------------------------------
`define CLK_HZ 125000000
`define FLUSH_STEP_US 1000
`define FLUSH_MS_MIN 8'h01
`define STROBE_CYCLES 4'h4
`endif

/* File: design/byte_fifo.v */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
)
(
   input wire clk,
   input wire rst_n,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready,
   output wire [AW:0] level
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem[rd_q];
   assign level = cnt_q;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_q] <= in_data;
      end
   end
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule // byte_fifo

/* File: design/channel_bitbang_wake_control.v */
// per-channel bit-bang port, prescaler, wakeup, flush timer, power and reset
`timescale 1ns/1ps
`include "chan_defines.vh"
module channel_bitbang_wake_control #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3,
   parameter MS_CYCLES = (`CLK_HZ / 1000) * `FLUSH_STEP_US / 1000
)
(
   input wire clk,
   input wire rst_n,
   input wire base_mode,
   input wire [7:0] io_mode_cmd,
   input wire io_mode_load,
   input wire [7:0] pin_dir,
   input wire [14:0] div_int,
   input wire [2:0] div_frac,
   input wire [7:0] flush_ms,
   input wire enumerated,
   input wire suspended,
   input wire remote_wake_en,
   input wire pulldown_en,
   input wire [7:0] tx_data,
   input wire tx_valid,
   output reg tx_ready,
   output reg [7:0] rx_data,
   output reg rx_valid,
   input wire rx_ready,
   input wire rx_level_nonzero,
   input wire bulk_in_req,
   output reg flush_now,
   output reg resume_req,
   input wire send_now_or_wakeup_n,
   input wire [7:0] port_in,
   output reg [7:0] port_out,
   output reg [7:0] port_oe,
   output reg wr_strobe_n,
   output reg rd_strobe_n,
   output reg [7:0] io_pulldown,
   output reg power_on_enable_n,
   output reg reset_output_n,
   output reg bitbang_active,
   output reg [1:0] mode_state
);
   // ----------------------------------------
   // mode and pin synchronisers
   // ----------------------------------------
   localparam ST_NORMAL = 2'b00;
   localparam ST_ASYNC = 2'b01;
   localparam ST_SYNC = 2'b10;
   reg [1:0] mode_q;
   reg [7:0] pin_s1_q;
   reg [7:0] pin_s2_q;
   reg wu_s1_q;
   reg wu_s2_q;
   reg wu_prev_q;
   wire wu_fall;
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         mode_q <= ST_NORMAL;
         pin_s1_q <= 8'h00;
         pin_s2_q <= 8'h00;
         // the wake pin idles high; its flops reset high so no false edge follows reset
         wu_s1_q <= 1'b1;
         wu_s2_q <= 1'b1;
         wu_prev_q <= 1'b1;
      end
      else
      begin
         pin_s1_q <= port_in;
         pin_s2_q <= pin_s1_q;
         wu_s1_q <= send_now_or_wakeup_n;
         wu_s2_q <= wu_s1_q;
         wu_prev_q <= wu_s2_q;
         if (io_mode_load)
         begin
            case (io_mode_cmd)
               `IOMODE_NORMAL: mode_q <= ST_NORMAL;
               `IOMODE_ASYNC_BB: mode_q <= ST_ASYNC;
               `IOMODE_SYNC_BB: mode_q <= ST_SYNC;
               default: mode_q <= mode_q;
            endcase
         end
      end
   end
   assign wu_fall = wu_prev_q && !wu_s2_q;
   // ----------------------------------------
   // fractional prescaler
   // ----------------------------------------
   // divisor clamped into range so a bad setting cannot stall the pacer
   reg [14:0] div_clamped;
   reg [14:0] pre_cnt_q;
   reg [3:0] frac_acc_q;
   reg tick_q;
   wire [3:0] frac_sum;
   wire extra;
   always @*
   begin
      if (div_int < `DIV_INT_MIN)
      begin
         div_clamped = `DIV_INT_MIN;
      end
      else if (div_int > `DIV_INT_MAX)
      begin
         div_clamped = `DIV_INT_MAX;
      end
      else
      begin
         div_clamped = div_int;
      end
   end
   assign frac_sum = frac_acc_q[2:0] + {1'b0, div_frac};
   assign extra = frac_sum[3];
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         pre_cnt_q <= 15'h0000;
         frac_acc_q <= 4'h0;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= 1'b0;
         if (pre_cnt_q == 15'h0000)
         begin
            // one extra cycle whenever the eighths accumulator carries
            pre_cnt_q <= div_clamped - 15'h0001 + {14'h0000, extra};
            frac_acc_q <= {1'b0, frac_sum[2:0]};
            tick_q <= 1'b1;
         end
         else
         begin
            pre_cnt_q <= pre_cnt_q - 15'h0001;
         end
      end
   end
   // ----------------------------------------
   // transmit fifo and bit-bang engine
   // ----------------------------------------
   wire [7:0] fifo_data;
   wire fifo_valid;
   wire fifo_in_ready;
   reg fifo_pop;
   wire [FIFO_AW:0] fifo_level;
   wire tx_push;
   reg [FIFO_AW:0] level_next;
   // tx_ready is registered, so it is built from the level of the next cycle;
   // a delayed copy of not-full would drop or repeat a byte at the full edge
   assign tx_push = tx_valid && tx_ready && fifo_in_ready;
   always @*
   begin
      level_next = fifo_level;
      if (tx_push)
      begin
         level_next = level_next + {{FIFO_AW{1'b0}}, 1'b1};
      end
      if (fifo_pop)
      begin
         level_next = level_next - {{FIFO_AW{1'b0}}, 1'b1};
      end
   end
   byte_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_txfifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_data(tx_data),
      .in_valid(tx_push),
      .in_ready(fifo_in_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .level(fifo_level)
   );
   reg [3:0] wr_cnt_q;
   reg [3:0] rd_cnt_q;
   reg sync_rd_pend_q;
   wire bb_on;
   assign bb_on = (mode_q != ST_NORMAL);
   // async mode reads the port on every tick with no read strobe still running, even with nothing written
   always @*
   begin
      fifo_pop = 1'b0;
      if (bb_on && tick_q && fifo_valid && wr_cnt_q == 4'h0)
      begin
         fifo_pop = 1'b1;
      end
   end
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         port_out <= 8'h00;
         port_oe <= 8'h00;
         wr_strobe_n <= 1'b1;
         rd_strobe_n <= 1'b1;
         wr_cnt_q <= 4'h0;
         rd_cnt_q <= 4'h0;
         sync_rd_pend_q <= 1'b0;
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
         tx_ready <= 1'b0;
         bitbang_active <= 1'b0;
         mode_state <= ST_NORMAL;
      end
      else
      begin
         tx_ready <= (level_next != FIFO_DEPTH[FIFO_AW:0]);
         bitbang_active <= bb_on;
         mode_state <= mode_q;
         port_oe <= bb_on ? pin_dir : 8'h00;
         if (rx_valid && rx_ready)
         begin
            rx_valid <= 1'b0;
         end
         if (wr_cnt_q != 4'h0)
         begin
            wr_cnt_q <= wr_cnt_q - 4'h1;
            wr_strobe_n <= (wr_cnt_q == 4'h1);
         end
         if (rd_cnt_q != 4'h0)
         begin
            rd_cnt_q <= rd_cnt_q - 4'h1;
            rd_strobe_n <= (rd_cnt_q == 4'h1);
         end
         if (fifo_pop)
         begin
            port_out <= fifo_data;
            wr_strobe_n <= 1'b0;
            wr_cnt_q <= `STROBE_CYCLES;
            sync_rd_pend_q <= (mode_q == ST_SYNC);
         end
         // a full rx path drops the sample rather than stall the pacer
         if (bb_on && tick_q && rd_cnt_q == 4'h0 &&
             ((mode_q == ST_ASYNC) || sync_rd_pend_q))
         begin
            rd_strobe_n <= 1'b0;
            rd_cnt_q <= `STROBE_CYCLES;
            // a write on this same tick must keep its own read pending
            sync_rd_pend_q <= fifo_pop && (mode_q == ST_SYNC);
            if (!rx_valid || rx_ready)
            begin
               rx_data <= pin_s2_q;
               rx_valid <= 1'b1;
            end
         end
      end
   end
   // ----------------------------------------
   // wakeup, flush timer, power and reset
   // ----------------------------------------
   reg [16:0] ms_cnt_q;
   reg [7:0] to_cnt_q;
   reg flush_pend_q;
   reg [7:0] to_len;
   always @*
   begin
      to_len = flush_ms;
      if (flush_ms < `FLUSH_MS_MIN)
      begin
         to_len = `FLUSH_MS_MIN;
      end
   end
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         ms_cnt_q <= 17'h00000;
         to_cnt_q <= 8'h00;
         flush_pend_q <= 1'b0;
         flush_now <= 1'b0;
         resume_req <= 1'b0;
         power_on_enable_n <= 1'b1;
         io_pulldown <= 8'h00;
         reset_output_n <= 1'b0;
      end
      else
      begin
         reset_output_n <= 1'b1;
         resume_req <= 1'b0;
         power_on_enable_n <= !(enumerated && !suspended);
         io_pulldown <= (pulldown_en && power_on_enable_n) ? 8'hFF : 8'h00;
         if (wu_fall && suspended && remote_wake_en)
         begin
            resume_req <= 1'b1;
         end
         // the base mode changes neither which pins carry strobes nor the timing
         // the ms tick runs free, so the first step of a timeout may be short
         if (ms_cnt_q == MS_CYCLES[16:0] - 17'h00001)
         begin
            ms_cnt_q <= 17'h00000;
         end
         else
         begin
            ms_cnt_q <= ms_cnt_q + 17'h00001;
         end
         if (tx_valid || fifo_pop || !rx_level_nonzero)
         begin
            to_cnt_q <= to_len;
         end
         else if (ms_cnt_q == 17'h00000 && to_cnt_q != 8'h00)
         begin
            to_cnt_q <= to_cnt_q - 8'h01;
         end
         // set wins over the clear from a served bulk-in
         if ((wu_fall && !suspended && rx_level_nonzero) ||
             (to_cnt_q == 8'h01 && ms_cnt_q == 17'h00000 && rx_level_nonzero))
         begin
            flush_pend_q <= 1'b1;
         end
         else if (bulk_in_req)
         begin
            flush_pend_q <= 1'b0;
         end
         flush_now <= flush_pend_q && bulk_in_req;
      end
   end
   // base_mode only documents which pin map the strobes use
   wire unused_base;
   assign unused_base = base_mode;
endmodule // channel_bitbang_wake_control

/* File: test/ext_logic.sv */
// far-side logic model on the bit-bang port
`timescale 1ns/1ps
module ext_logic (
   input logic clk,
   input logic [7:0] port_out,
   input logic [7:0] port_oe,
   input logic wr_strobe_n,
   output logic [7:0] port_in,
   output logic [7:0] last_wr
);
   initial port_in = 8'h00;
   // undriven bits toggle so a floating line never reads back by luck
   always @(posedge clk)
      port_in <= (port_oe & port_out) | (~port_oe & ~port_in);
   // the write strobe clocks this latch, as outside logic would use it
   always @(posedge wr_strobe_n)
      last_wr <= port_in;
endmodule // ext_logic

/* File: test/chan_checker_sva.sv */
// assertion checker for the channel bit-bang and wake block
`timescale 1ns/1ps
module chan_checker (
   input logic clk,
   input logic rst_n,
   input logic enumerated,
   input logic suspended,
   input logic pulldown_en,
   input logic power_on_enable_n,
   input logic [7:0] io_pulldown,
   input logic reset_output_n,
   input logic resume_req,
   input logic remote_wake_en,
   input logic send_now_or_wakeup_n,
   input logic flush_now,
   input logic bulk_in_req,
   input logic wr_strobe_n,
   input logic io_mode_load,
   input logic [7:0] io_mode_cmd,
   input logic [1:0] mode_state,
   input logic bitbang_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_pwr_on;
      enumerated && !suspended |=> !power_on_enable_n;
   endproperty
   a_pwr_on: assert property (p_pwr_on) else $error("power stays off");
   property p_pwr_off;
      suspended |=> power_on_enable_n;
   endproperty
   a_pwr_off: assert property (p_pwr_off) else $error("power on in suspend");
   property p_pulldown;
      pulldown_en && $past(pulldown_en) && power_on_enable_n |=> io_pulldown == 8'hFF;
   endproperty
   a_pulldown: assert property (p_pulldown) else $error("no pull-down");
   // reset output must be checked while reset is low too
   property p_rst_out;
      disable iff (1'b0) 1'b1 |=> reset_output_n == $past(rst_n);
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("reset output wrong");
   property p_wake;
      $fell(send_now_or_wakeup_n) && suspended && remote_wake_en |-> ##[1:6] resume_req;
   endproperty
   a_wake: assert property (p_wake) else $error("no resume request");
   property p_flush;
      flush_now |-> $past(bulk_in_req);
   endproperty
   a_flush: assert property (p_flush) else $error("flush without request");
   property p_wr_len;
      $fell(wr_strobe_n) |-> !wr_strobe_n [*4] ##1 wr_strobe_n;
   endproperty
   a_wr_len: assert property (p_wr_len) else $error("write strobe length");
   property p_mode;
      io_mode_load && io_mode_cmd == 8'h04 |-> ##2 mode_state == 2'h2 && bitbang_active;
   endproperty
   a_mode: assert property (p_mode) else $error("sync mode not entered");
endmodule // chan_checker
bind channel_bitbang_wake_control chan_checker i_chk (.*);

/* File: test/tb_top.sv */
// self-checking bench for the channel bit-bang and wake block
`timescale 1ns/1ps
module tb_top;
   logic clk, rst_n, base_mode, io_mode_load, tx_valid, tx_ready, rx_valid, rx_ready;
   logic enumerated, suspended, remote_wake_en, pulldown_en, rx_level_nonzero, bulk_in_req;
   logic flush_now, resume_req, send_now_or_wakeup_n, wr_strobe_n, rd_strobe_n;
   logic power_on_enable_n, reset_output_n, bitbang_active;
   logic [7:0] io_mode_cmd, pin_dir, flush_ms, tx_data, rx_data, port_in, port_out;
   logic [7:0] port_oe, io_pulldown, last_wr;
   logic [14:0] div_int;
   logic [2:0] div_frac;
   logic [1:0] mode_state;
   logic [7:0] rx_q[$], wr_q[$];
   time t_q[$];
   int n_fail, tests_run, n_rd;
   // short ms step keeps the flush timer tests brief
   channel_bitbang_wake_control #(.MS_CYCLES(50)) i_dut (.*);
   ext_logic i_ext (.*);
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1)
         rx_q.push_back(rx_data);
      if ($fell(wr_strobe_n))
      begin
         wr_q.push_back(port_out);
         t_q.push_back($time);
      end
      if ($fell(rd_strobe_n))
         n_rd++;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic set_mode(input logic [7:0] c);
      io_mode_cmd <= c;
      io_mode_load <= 1'b1;
      @(posedge clk);
      io_mode_load <= 1'b0;
      cyc(3);
   endtask
   task automatic push(input logic [7:0] d, input int n);
      tx_valid <= 1'b1;
      for (int i = 0; i < n; i++)
      begin
         tx_data <= d + 8'(i);
         do @(posedge clk); while (tx_ready !== 1'b1);
      end
      tx_valid <= 1'b0;
   endtask
   task automatic bulk(input logic exp);
      bulk_in_req <= 1'b1;
      @(posedge clk);
      bulk_in_req <= 1'b0;
      @(posedge clk);
      chk(flush_now, exp);
   endtask
   task automatic wake(output logic seen);
      seen = 1'b0;
      send_now_or_wakeup_n <= 1'b0;
      repeat (8)
      begin
         @(posedge clk);
         seen |= resume_req;
      end
      send_now_or_wakeup_n <= 1'b1;
      cyc(4);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_power;
      enumerated <= 1'b1;
      pulldown_en <= 1'b1;
      cyc(3);
      chk(power_on_enable_n, 0);
      chk(io_pulldown, 0);
      suspended <= 1'b1;
      cyc(3);
      chk(power_on_enable_n, 1);
      chk(io_pulldown, 8'hFF);
      suspended <= 1'b0;
      $display("power done");
   endtask
   task automatic t_mode;
      logic [7:0] c[4] = '{8'h01, 8'h02, 8'h04, 8'h00};
      logic [1:0] e[4] = '{2'h1, 2'h1, 2'h2, 2'h0};
      for (int i = 0; i < 4; i++)
      begin
         set_mode(c[i]);
         chk(mode_state, e[i]);
         chk(bitbang_active, e[i] != 2'h0);
      end
      $display("mode done");
   endtask
   task automatic t_async;
      set_mode(8'h01);
      wr_q.delete();
      t_q.delete();
      push(8'hA0, 8);
      for (int k = 0; k < 500 && wr_q.size() < 8; k++)
         @(posedge clk);
      cyc(8);
      chk(wr_q.size(), 8);
      for (int i = 0; i < 8; i++)
         chk(wr_q[i], 8'hA0 + 8'(i));
      // six ticks of 10.5 cycles
      chk((t_q[6] - t_q[0]) / 8, 63);
      chk(last_wr, 8'hA7);
      chk(port_oe, 8'hFF);
      $display("async done");
   endtask
   task automatic t_sync;
      int r0;
      set_mode(8'h04);
      cyc(4);
      rx_q.delete();
      r0 = n_rd;
      cyc(40);
      chk(rx_q.size(), 0);
      push(8'h5A, 2);
      cyc(60);
      chk(rx_q.size(), 2);
      chk(rx_q[0], 8'h5A);
      chk(rx_q[1], 8'h5B);
      chk(n_rd - r0, 2);
      $display("sync done");
   endtask
   task automatic t_wake;
      logic s;
      suspended <= 1'b1;
      cyc(2);
      wake(s);
      chk(s, 0);
      remote_wake_en <= 1'b1;
      cyc(2);
      wake(s);
      chk(s, 1);
      suspended <= 1'b0;
      rx_level_nonzero <= 1'b1;
      bulk(0);
      wake(s);
      bulk(1);
      bulk(0);
      $display("wake done");
   endtask
   task automatic t_timeout;
      rx_level_nonzero <= 1'b0;
      flush_ms <= 8'h03;
      cyc(2);
      rx_level_nonzero <= 1'b1;
      cyc(40);
      bulk(0);
      cyc(150);
      bulk(1);
      rx_level_nonzero <= 1'b0;
      flush_ms <= 8'h00;
      cyc(2);
      rx_level_nonzero <= 1'b1;
      cyc(110);
      bulk(1);
      $display("timeout done");
   endtask
   initial
   begin
      n_fail = 0;
      tests_run = 0;
      {rst_n, io_mode_load, tx_valid, enumerated, suspended, remote_wake_en} = '0;
      {pulldown_en, rx_level_nonzero, bulk_in_req} = '0;
      {base_mode, rx_ready, send_now_or_wakeup_n} = 3'h7;
      {io_mode_cmd, tx_data} = '0;
      pin_dir = 8'hFF;
      flush_ms = 8'hFF;
      div_int = 15'h000A;
      div_frac = 3'h4;
      repeat (16) @(posedge clk);
      chk(reset_output_n, 0);
      chk({wr_strobe_n, rd_strobe_n, power_on_enable_n}, 3'h7);
      rst_n <= 1'b1;
      cyc(2);
      chk(reset_output_n, 1);
      t_power();
      t_mode();
      t_async();
      t_sync();
      t_wake();
      t_timeout();
      stop_test();
   end
   initial
   begin
      #50us;
      n_fail++;
      stop_test();
   end
endmodule // tb_top
